// [logic/oht_map.vh]
// Behaviour
// - After a level command changes a line with a nonzero hold setting, the line keeps that level for its hold time and then returns to its default level.
// - Each line's hold setting takes 0 to 0x1770 in 100 ms steps and resets to zero.
// - Hold settings for lines 15 to 19 exist only on the surface package, not on the pin insert package.
// - Bit n of the level word drives line n, and its hold time comes from line n's own setting.
// - The level word is limited to 0x7fff on the pin insert package and 0xfffff on the surface package.
// - A level bit acts only when its output enable mask bit is set.
// - A line's default level is low for configuration code 4 and high for code 5.
`ifndef OHT_MAP_VH
`define OHT_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OHT_ADDR_LEVEL 12'h000
`define OHT_ADDR_MASK 12'h004
`define OHT_ADDR_CFG_LO 12'h008
`define OHT_ADDR_CFG_HI 12'h00c
`define OHT_ADDR_STATE 12'h010
`define OHT_ADDR_ACTIVE 12'h014
`define OHT_ADDR_VARIANT 12'h018
`define OHT_ADDR_HOLD0 12'h040

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define OHT_HOLD_MAX 13'h1770
`define OHT_HOLD_W 13
`define OHT_MASK_SURFACE 20'hfffff
`define OHT_MASK_PIN_INSERT 20'h07fff
`define OHT_CFG_LOW 3'h4
`define OHT_CFG_HIGH 3'h5
`define OHT_CFG_RESET 3'h4
`define OHT_CFG_W 3

// ----------------------------------------
// Timing
// ----------------------------------------
`define OHT_TICK_MS 100
`define OHT_CLK_MHZ 250
`define OHT_TICK_CYCLES (`OHT_TICK_MS * 1000 * `OHT_CLK_MHZ)

`endif

// [logic/oht_tick_div.v]
`timescale 1ns/100ps
`default_nettype none
module oht_tick_div #(
  parameter integer TICK_CYCLES = 25000000
) (
  input wire clk_sys_in,
  input wire reset_n_in,
  output reg tick_out
);
  reg [31:0] count_reg;

  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_reg <= 32'h0;
      tick_out <= 1'b0;
    end else if (count_reg == TICK_CYCLES - 1) begin
      count_reg <= 32'h0;
      tick_out <= 1'b1;
    end else begin
      count_reg <= count_reg + 32'h1;
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [logic/oht_line_timer.v]
`timescale 1ns/100ps
`default_nettype none
`include "oht_map.vh"
module oht_line_timer (
  input wire clk_sys_in,
  input wire reset_n_in,
  input wire tick_in,
  input wire load_in,
  input wire [`OHT_HOLD_W-1:0] hold_in,
  output reg active_out,
  output reg expire_out
);
  reg [`OHT_HOLD_W-1:0] remain_reg;

  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      remain_reg <= {`OHT_HOLD_W{1'b0}};
      active_out <= 1'b0;
      expire_out <= 1'b0;
    end else begin
      expire_out <= 1'b0;
      if (load_in) begin
        remain_reg <= hold_in;
        active_out <= (hold_in != {`OHT_HOLD_W{1'b0}});
      end else if (active_out && tick_in) begin
        if (remain_reg == {{(`OHT_HOLD_W-1){1'b0}}, 1'b1}) begin
          active_out <= 1'b0;
          expire_out <= 1'b1;
        end
        remain_reg <= remain_reg - {{(`OHT_HOLD_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// [logic/oht_output_hold_timers.v]
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "oht_map.vh"
module oht_output_hold_timers #(
  parameter integer NUM_LINES = 20,
  parameter integer SURFACE_PACKAGE = 1,
  parameter integer TICK_CYCLES = `OHT_TICK_CYCLES
) (
  // Clock and reset
  input wire clk_sys_in,
  input wire reset_n_in,
  // APB slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  // Lines
  output reg [19:0] digital_line_out
);
  // ----------------------------------------
  // Variant limits
  // ----------------------------------------
  wire [19:0] variant_mask;
  assign variant_mask = (SURFACE_PACKAGE != 0) ? `OHT_MASK_SURFACE :
    `OHT_MASK_PIN_INSERT;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [19:0] output_enable_mask_reg;
  reg [19:0] level_reg;
  reg [`OHT_CFG_W-1:0] cfg_reg [0:19];
  reg [`OHT_HOLD_W-1:0] hold_reg [0:19];
  reg [19:0] default_level;
  reg [19:0] load_vec;
  wire [19:0] active_vec;
  wire [19:0] expire_vec;
  wire tick;
  wire wr_en;
  wire rd_en;
  wire hold_hit;
  wire [4:0] hold_idx;
  wire [11:0] hold_off;
  wire [19:0] cmd_level;
  integer i;
  integer j;
  integer k;

  // Write lands on the completing edge
  assign wr_en = psel_in && penable_in && pwrite_in && pready_out;
  assign rd_en = psel_in && penable_in && !pwrite_in && !pready_out;
  assign hold_off = paddr_in - `OHT_ADDR_HOLD0;
  assign hold_idx = hold_off[6:2];
  assign hold_hit = (paddr_in >= `OHT_ADDR_HOLD0) &&
    (hold_off[11:7] == 5'h00) && (hold_off[1:0] == 2'h0) &&
    (hold_idx < 5'd20) && variant_mask[hold_idx];
  assign cmd_level = pwdata_in[19:0] & variant_mask;

  // ----------------------------------------
  // Tick and per-line timers
  // ----------------------------------------
  oht_tick_div #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_div (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .tick_out(tick)
  );

  genvar g;
  generate
    for (g = 0; g < 20; g = g + 1) begin : g_line
      oht_line_timer u_timer (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .tick_in(tick),
        .load_in(load_vec[g]),
        .hold_in(hold_reg[g]),
        .active_out(active_vec[g]),
        .expire_out(expire_vec[g])
      );
    end
  endgenerate

  always @* begin
    for (j = 0; j < 20; j = j + 1) begin
      default_level[j] = (cfg_reg[j] == `OHT_CFG_HIGH);
      load_vec[j] = wr_en && (paddr_in == `OHT_ADDR_LEVEL) &&
        output_enable_mask_reg[j] && variant_mask[j];
    end
  end

  // ----------------------------------------
  // Register writes and line drive
  // ----------------------------------------
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      output_enable_mask_reg <= 20'h00000;
      level_reg <= 20'h00000;
      digital_line_out <= 20'h00000;
      for (i = 0; i < 20; i = i + 1) begin
        cfg_reg[i] <= `OHT_CFG_RESET;
        hold_reg[i] <= {`OHT_HOLD_W{1'b0}};
      end
    end else begin
      for (i = 0; i < 20; i = i + 1) begin
        if (load_vec[i]) begin
          digital_line_out[i] <= cmd_level[i];
          level_reg[i] <= cmd_level[i];
        end else if (expire_vec[i] || !variant_mask[i]) begin
          digital_line_out[i] <= default_level[i] & variant_mask[i];
        end
      end
      if (wr_en) begin
        if (paddr_in == `OHT_ADDR_MASK)
          output_enable_mask_reg <= cmd_level;
        if (paddr_in == `OHT_ADDR_CFG_LO)
          for (i = 0; i < 10; i = i + 1)
            if (pwdata_in[i*3 +: 3] == `OHT_CFG_LOW ||
              pwdata_in[i*3 +: 3] == `OHT_CFG_HIGH)
              cfg_reg[i] <= pwdata_in[i*3 +: 3];
        if (paddr_in == `OHT_ADDR_CFG_HI)
          for (i = 0; i < 10; i = i + 1)
            if (variant_mask[i+10] &&
              (pwdata_in[i*3 +: 3] == `OHT_CFG_LOW ||
              pwdata_in[i*3 +: 3] == `OHT_CFG_HIGH))
              cfg_reg[i+10] <= pwdata_in[i*3 +: 3];
        if (hold_hit && pwdata_in[12:0] <= `OHT_HOLD_MAX &&
          pwdata_in[31:13] == 19'h0)
          hold_reg[hold_idx] <= pwdata_in[12:0];
      end
    end
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  reg [31:0] rdata_next;
  reg err_next;
  always @* begin
    rdata_next = 32'h0;
    err_next = 1'b0;
    if (hold_hit) begin
      rdata_next = {19'h0, hold_reg[hold_idx]};
    end else begin
      case (paddr_in)
        `OHT_ADDR_LEVEL: rdata_next = {12'h0, level_reg};
        `OHT_ADDR_MASK: rdata_next = {12'h0, output_enable_mask_reg};
        `OHT_ADDR_CFG_LO: begin
          for (k = 0; k < 10; k = k + 1)
            rdata_next[k*3 +: 3] = cfg_reg[k];
        end
        `OHT_ADDR_CFG_HI: begin
          for (k = 0; k < 10; k = k + 1)
            rdata_next[k*3 +: 3] = cfg_reg[k+10];
        end
        `OHT_ADDR_STATE: rdata_next = {12'h0, digital_line_out};
        `OHT_ADDR_ACTIVE: rdata_next = {12'h0, active_vec};
        `OHT_ADDR_VARIANT: rdata_next = {12'h0, variant_mask};
        default: err_next = 1'b1;
      endcase
    end
  end

  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0;
      pslverr_out <= 1'b0;
    end else if (psel_in && penable_in && !pready_out) begin
      pready_out <= 1'b1;
      pslverr_out <= err_next;
      prdata_out <= rd_en ? rdata_next : 32'h0;
    end else begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [verification/oht_apb_host.sv]
`timescale 1ns/100ps
`default_nettype none
module oht_apb_host (
  // Clock and answer
  input wire logic clk_sys_in,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  // Request
  output logic psel_out = 1'b0,
  output logic penable_out = 1'b0,
  output logic pwrite_out = 1'b0,
  output logic [11:0] paddr_out = 12'h0,
  output logic [31:0] pwdata_out = 32'h0
);
  task automatic xfer(input logic w, input logic [11:0] a,
                      inout logic [31:0] d, output logic e);
    @(posedge clk_sys_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= (a == 12'h000) ? (d & 32'h000fffff) : d;
    @(posedge clk_sys_in);
    penable_out <= 1'b1;
    do @(posedge clk_sys_in); while (pready_in !== 1'b1);
    if (!w)
      d = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    paddr_out <= ~a;
    pwdata_out <= ~d;
  endtask
endmodule
`default_nettype wire

// [verification/oht_output_hold_timers_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module oht_output_hold_timers_assertions (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [19:0] digital_line_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  logic [19:0] msk_reg;
  wire logic acc = psel_in && penable_in && !pready_out;
  wire logic done = psel_in && penable_in && pready_out;
  // ----------------------------------------
  // Mask shadow
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
    if (!reset_n_in)
      msk_reg <= 20'h0;
    else if (done && pwrite_in && paddr_in == 12'h004)
      msk_reg <= pwdata_in[19:0];
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_access;
    psel_in && penable_in;
  endsequence
  a_ready_wait: assert property (s_setup ##1 s_access |=> pready_out)
    else $error("pready late");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready too long");
  a_ready_cause: assert property (pready_out |-> s_access)
    else $error("pready outside access");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  a_unmapped_err: assert property (acc && paddr_in == 12'h020 |=> pslverr_out)
    else $error("unmapped not refused");
  a_mapped_ok: assert property (acc && paddr_in == 12'h000 |=> !pslverr_out)
    else $error("mapped refused");
  a_line_set: assert property (
    done && pwrite_in && paddr_in == 12'h000 |=>
    ((digital_line_out ^ $past(pwdata_in[19:0])) & msk_reg) == 20'h0)
    else $error("line level wrong");
  a_reset_low: assert property (
    disable iff (1'b0) !reset_n_in |=> digital_line_out == 20'h0)
    else $error("line not low in reset");
endmodule
bind oht_output_hold_timers oht_output_hold_timers_assertions chk_u (
  .clk_sys_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .pready_out, .pslverr_out, .digital_line_out);
`default_nettype wire

// [verification/oht_output_hold_timers_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module oht_output_hold_timers_bench;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic psel_in, penable_in, pwrite_in, pready_out, pslverr_out, eb;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rnd;
  logic [19:0] digital_line_out, exp_ln;
  int err_total = 0;
  int n_checks = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  oht_output_hold_timers #(.TICK_CYCLES(10)) dut_u (.clk_sys_in,
    .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .digital_line_out);
  oht_apb_host host_u (.clk_sys_in, .prdata_in(prdata_out),
    .pready_in(pready_out), .pslverr_in(pslverr_out), .psel_out(psel_in),
    .penable_out(penable_in), .pwrite_out(pwrite_in),
    .paddr_out(paddr_in), .pwdata_out(pwdata_in));
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] v);
    host_u.xfer(1'b1, a, v, eb);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] v);
    logic [31:0] d;
    host_u.xfer(1'b0, a, d, eb);
    chk("rdata", v, d);
  endtask
  task automatic ln(int n);
    repeat (n) @(posedge clk_sys_in);
    chk("lines", {12'h0, exp_ln}, {12'h0, digital_line_out});
  endtask
  initial begin
    repeat (3000) @(posedge clk_sys_in);
    err_total++;
    finish_test();
  end
  initial begin
    rnd = $urandom(45);
    repeat (8) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    rd(12'h040, 32'h0);
    rd(12'h00c, 32'h24924924);
    rd(12'h018, 32'h000fffff);
    host_u.xfer(1'b0, 12'h020, rnd, eb);
    chk("slverr", 32'h1, {31'h0, eb});
    wr(12'h04c, 32'h1771);
    rd(12'h04c, 32'h0);
    wr(12'h07c, 32'h1770);
    rd(12'h07c, 32'h1770);
    wr(12'h004, 32'h000ffff7);
    wr(12'h000, 32'h8);
    exp_ln = 20'h0;
    ln(1);
    wr(12'h004, 32'h000fffff);
    wr(12'h04c, 32'h3);
    rnd = $urandom | 32'h8;
    wr(12'h000, rnd);
    exp_ln = rnd[19:0];
    ln(12);
    exp_ln[3] = 1'b0;
    ln(25);
    wr(12'h008, 32'h24924b24);
    wr(12'h000, 32'h0);
    exp_ln = 20'h0;
    ln(1);
    exp_ln[3] = 1'b1;
    ln(37);
    finish_test();
  end
endmodule
`default_nettype wire
